// >>> mcss_pkg.sv
package mcss_pkg;
    localparam logic [13:0] PC_RESET = 14'h0000;
    localparam logic [7:0] SP_RESET = 8'h00;
    localparam logic [7:0] SP_STEP = 8'h01;
    localparam logic [7:0] FRAME_BYTES = 8'h02;
    localparam logic [7:0] LOW_STEP = 8'h01;
    localparam logic [5:0] PAGE_STEP = 6'h01;
    localparam logic [7:0] OP_LDA_DIR = 8'h1a;
    localparam logic [7:0] OP_LDA_IDX = 8'h1b;
    localparam logic [7:0] OP_LDX_IMM = 8'h1c;
    localparam logic [7:0] OP_LDX_DIR = 8'h1d;
    localparam logic [7:0] OP_RSVD = 8'h1e;
    localparam logic [7:0] OP_PAGE = 8'h1f;
    localparam logic [7:0] OP_SWAP_DSP = 8'h2d;
    localparam logic [7:0] OP_PUSH_A = 8'h2e;
    localparam logic [7:0] OP_POP_A = 8'h2f;
    localparam logic [7:0] OP_CPL = 8'h3a;
    localparam logic [7:0] OP_SHL = 8'h3b;
    localparam logic [7:0] OP_ASHR = 8'h3c;
    localparam logic [7:0] OP_ROLC = 8'h3d;
    localparam logic [7:0] OP_RORC = 8'h3e;
    localparam logic [7:0] OP_SUB_RET = 8'h3f;
    localparam logic [7:0] OP_A_FROM_X = 8'h40;
    localparam logic [7:0] OP_X_FROM_A = 8'h41;
    localparam logic [7:0] OP_CALL_IRQ = 8'h50;
    localparam logic [7:0] OP_PSP_LOAD = 8'h60;
    localparam logic [7:0] OP_INT_OFF = 8'h70;
    localparam logic [7:0] OP_INT_ON = 8'h72;
    localparam logic [7:0] OP_INT_RET = 8'h73;
    localparam logic [3:0] NIB_CALL_A = 4'h5;
    localparam logic [3:0] NIB_CALL_B = 4'h9;
    localparam logic [3:0] NIB_JMP = 4'h8;
    localparam logic [3:0] NIB_JZ = 4'ha;
    localparam logic [3:0] NIB_JNZ = 4'hb;
    localparam logic [3:0] NIB_JC = 4'hc;
    localparam logic [3:0] NIB_JNC = 4'hd;
    localparam logic [3:0] NIB_ACCUMULATOR_JUMP_OP = 4'he;
    localparam logic [3:0] NIB_INDEX = 4'hf;
    localparam logic [3:0] CYC_BASE = 4'h4;
    localparam logic [3:0] CYC_DIR = 4'h5;
    localparam logic [3:0] CYC_IDX = 4'h6;
    localparam logic [3:0] CYC_ACCUMULATOR_JUMP_OP = 4'h7;
    localparam logic [3:0] CYC_RET = 4'h8;
    localparam logic [3:0] CYC_CALL = 4'ha;
    localparam logic [3:0] CYC_INDEX = 4'he;
    localparam logic [3:0] STEP_ONE = 4'h1;
    localparam logic [3:0] ST_FETCH = 4'h0;
    localparam logic [3:0] ST_OPND = 4'h1;
    localparam logic [3:0] ST_X0 = 4'h2;
    localparam logic [3:0] ST_X1 = 4'h3;
    localparam logic [3:0] ST_X2 = 4'h4;
    localparam logic [3:0] ST_X4 = 4'h6;
    typedef enum logic [1:0] {S_FETCH, S_OPND, S_EXEC} mcss_state_e;
    typedef struct packed {
        logic cf;
        logic zf;
        logic [5:0] pcHi;
    } mcss_frame_hi_s;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } mcss_ram_req_s;
endpackage

// >>> mcss_core.sv
`timescale 1ns/1ps
// Contract
// - 14-bit pc cleared, first fetch at 0
// - fetch advances low byte; page op advances upper
// - irq ack disables, saves two bytes upward
// - interrupt return pops two bytes, re-enables interrupts
// - call pushes pc and flags, ten cycles
// - subroutine return restores pc only, eight cycles
// - call stack pointer resets zero, loads from acc
// - pc unreadable; frames readable in data ram
// - push pre-decrements, pop post-increments
// - data stack pointer resets zero, wraps to top
// - immediate, direct and indexed operand modes
// - immediate operand is the second code byte
// - load opcodes and their cycle counts
// - conditional jumps five taken, four not
module mcss_core (
    input wire logic clk,
    input wire logic rst,
    output logic [13:0] pmAddr,
    input wire logic [7:0] pmData,
    output mcss_pkg::mcss_ram_req_s ramReq,
    input wire logic [7:0] ramRdata,
    input wire logic irqReq,
    input wire logic [13:0] irqVector,
    output logic irqAck,
    output logic intEnabled
);
    mcss_pkg::mcss_state_e state_reg, stateNext;
    logic [3:0] cyc_reg, cycNext;
    logic [7:0] op_reg, opNext, opnd_reg, opndNext;
    logic [13:0] pc_reg, pcNext, pmAddr_reg, pmAddrNext;
    logic [7:0] acc_reg, accNext, x_reg, xNext;
    logic [7:0] psp_reg, pspNext, dsp_reg, dspNext;
    logic cf_reg, cfNext, zf_reg, zfNext, ie_reg, ieNext;
    logic isIrq_reg, irqNext, irqAck_reg, ackNext;
    mcss_pkg::mcss_frame_hi_s hold_reg, holdNext;
    mcss_pkg::mcss_ram_req_s ram_reg, ramNext;
    logic tablePick;

    function automatic logic hasOperand(input logic [7:0] op);
        hasOperand = (op == mcss_pkg::OP_LDA_DIR) || (op == mcss_pkg::OP_LDA_IDX) ||
            (op == mcss_pkg::OP_LDX_IMM) || (op == mcss_pkg::OP_LDX_DIR) ||
            (op[7:4] == mcss_pkg::NIB_CALL_A) || (op[7:4] >= mcss_pkg::NIB_JMP);
    endfunction

    function automatic logic [3:0] cycleCount(input logic [7:0] op, input logic taken);
        case (op[7:4])
            mcss_pkg::NIB_CALL_A, mcss_pkg::NIB_CALL_B: cycleCount = mcss_pkg::CYC_CALL;
            mcss_pkg::NIB_JMP: cycleCount = mcss_pkg::CYC_DIR;
            mcss_pkg::NIB_JZ, mcss_pkg::NIB_JNZ, mcss_pkg::NIB_JC, mcss_pkg::NIB_JNC: begin
                cycleCount = taken ? mcss_pkg::CYC_DIR : mcss_pkg::CYC_BASE;
            end
            mcss_pkg::NIB_ACCUMULATOR_JUMP_OP: cycleCount = mcss_pkg::CYC_ACCUMULATOR_JUMP_OP;
            mcss_pkg::NIB_INDEX: cycleCount = mcss_pkg::CYC_INDEX;
            default: begin
                case (op)
                    mcss_pkg::OP_LDA_DIR, mcss_pkg::OP_LDX_DIR: cycleCount = mcss_pkg::CYC_DIR;
                    mcss_pkg::OP_LDA_IDX: cycleCount = mcss_pkg::CYC_IDX;
                    mcss_pkg::OP_PUSH_A, mcss_pkg::OP_POP_A: cycleCount = mcss_pkg::CYC_DIR;
                    mcss_pkg::OP_SWAP_DSP: cycleCount = mcss_pkg::CYC_DIR;
                    mcss_pkg::OP_SUB_RET, mcss_pkg::OP_INT_RET: cycleCount = mcss_pkg::CYC_RET;
                    default: cycleCount = mcss_pkg::CYC_BASE;
                endcase
            end
        endcase
    endfunction

    function automatic mcss_pkg::mcss_ram_req_s ramWrite(input logic [7:0] a,
                                                         input logic [7:0] d);
        ramWrite = '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    endfunction

    function automatic mcss_pkg::mcss_ram_req_s ramRead(input logic [7:0] a);
        ramRead = '{addr: a, wdata: '0, we: 1'b0, re: 1'b1};
    endfunction

    wire [3:0] opHi = op_reg[7:4];
    wire isCall = isIrq_reg || (opHi == mcss_pkg::NIB_CALL_A) || (opHi == mcss_pkg::NIB_CALL_B);
    wire isRet = !isIrq_reg &&
        ((op_reg == mcss_pkg::OP_SUB_RET) || (op_reg == mcss_pkg::OP_INT_RET));
    wire isCond = (opHi >= mcss_pkg::NIB_JZ) && (opHi <= mcss_pkg::NIB_JNC);
    wire condMet = (opHi == mcss_pkg::NIB_JZ) ? zf_reg :
                   (opHi == mcss_pkg::NIB_JNZ) ? !zf_reg :
                   (opHi == mcss_pkg::NIB_JC) ? cf_reg : !cf_reg;
    wire [3:0] lastCyc = cycleCount(op_reg, condMet) - mcss_pkg::STEP_ONE;
    // lower byte wraps inside its page; crossing needs the page op
    wire [13:0] pcInc = {pc_reg[13:8], pc_reg[7:0] + mcss_pkg::LOW_STEP};
    wire [13:0] target = {pc_reg[13:12], op_reg[3:0], opnd_reg};
    wire [13:0] accTarget = target + {6'h00, acc_reg};
    wire [7:0] idxAddr = x_reg + opnd_reg;
    wire mcss_pkg::mcss_frame_hi_s frameHi = '{cf: cf_reg, zf: zf_reg, pcHi: pc_reg[13:8]};
    wire mcss_pkg::mcss_frame_hi_s rdHi = ramRdata;

    always_comb begin
        stateNext = state_reg;
        cycNext = cyc_reg + mcss_pkg::STEP_ONE;
        opNext = op_reg;
        opndNext = opnd_reg;
        pcNext = pc_reg;
        accNext = acc_reg;
        xNext = x_reg;
        pspNext = psp_reg;
        dspNext = dsp_reg;
        cfNext = cf_reg;
        zfNext = zf_reg;
        ieNext = ie_reg;
        irqNext = isIrq_reg;
        holdNext = hold_reg;
        ramNext = '0;
        ackNext = 1'b0;
        tablePick = 1'b0;
        case (state_reg)
            mcss_pkg::S_FETCH: begin
                stateNext = mcss_pkg::S_OPND;
                cycNext = mcss_pkg::ST_OPND;
                if (irqReq && ie_reg) begin
                    // the frame then holds the address of the skipped fetch
                    irqNext = 1'b1;
                    ieNext = 1'b0;
                    ackNext = 1'b1;
                    opNext = mcss_pkg::OP_CALL_IRQ;
                end else begin
                    irqNext = 1'b0;
                    opNext = pmData;
                    pcNext = pcInc;
                end
            end
            mcss_pkg::S_OPND: begin
                stateNext = mcss_pkg::S_EXEC;
                if (!isIrq_reg && hasOperand(op_reg)) begin
                    opndNext = pmData;
                    pcNext = pcInc;
                end
            end
            mcss_pkg::S_EXEC: begin
                if (cyc_reg == lastCyc) begin
                    stateNext = mcss_pkg::S_FETCH;
                    cycNext = mcss_pkg::ST_FETCH;
                end
                if (isCall) begin
                    if (cyc_reg == mcss_pkg::ST_X0) begin
                        ramNext = ramWrite(psp_reg, pc_reg[7:0]);
                        pspNext = psp_reg + mcss_pkg::SP_STEP;
                    end else if (cyc_reg == mcss_pkg::ST_X1) begin
                        ramNext = ramWrite(psp_reg, frameHi);
                        pspNext = psp_reg + mcss_pkg::SP_STEP;
                    end else if (cyc_reg == mcss_pkg::ST_X2) begin
                        pcNext = isIrq_reg ? irqVector : target;
                    end
                end else if (isRet) begin
                    if (cyc_reg == mcss_pkg::ST_X0) begin
                        ramNext = ramRead(psp_reg - mcss_pkg::SP_STEP);
                        pspNext = psp_reg - mcss_pkg::SP_STEP;
                    end else if (cyc_reg == mcss_pkg::ST_X2) begin
                        holdNext = rdHi;
                        ramNext = ramRead(psp_reg - mcss_pkg::SP_STEP);
                        pspNext = psp_reg - mcss_pkg::SP_STEP;
                    end else if (cyc_reg == mcss_pkg::ST_X4) begin
                        pcNext = {hold_reg.pcHi, ramRdata};
                        if (op_reg == mcss_pkg::OP_INT_RET) begin
                            cfNext = hold_reg.cf;
                            zfNext = hold_reg.zf;
                            ieNext = 1'b1;
                        end
                    end
                end else if (cyc_reg == mcss_pkg::ST_X0) begin
                    case (op_reg)
                        mcss_pkg::OP_LDA_DIR: ramNext = ramRead(opnd_reg);
                        mcss_pkg::OP_LDX_DIR: ramNext = ramRead(opnd_reg);
                        mcss_pkg::OP_LDA_IDX: ramNext = ramRead(idxAddr);
                        mcss_pkg::OP_POP_A: ramNext = ramRead(dsp_reg);
                        mcss_pkg::OP_PUSH_A: dspNext = dsp_reg - mcss_pkg::SP_STEP;
                        mcss_pkg::OP_LDX_IMM: xNext = opnd_reg;
                        mcss_pkg::OP_PAGE: pcNext = {pc_reg[13:8] + mcss_pkg::PAGE_STEP,
                                                     pc_reg[7:0]};
                        mcss_pkg::OP_PSP_LOAD: pspNext = acc_reg;
                        mcss_pkg::OP_A_FROM_X: accNext = x_reg;
                        mcss_pkg::OP_X_FROM_A: xNext = acc_reg;
                        mcss_pkg::OP_INT_OFF: ieNext = 1'b0;
                        mcss_pkg::OP_INT_ON: ieNext = 1'b1;
                        mcss_pkg::OP_SWAP_DSP: begin
                            accNext = dsp_reg;
                            dspNext = acc_reg;
                        end
                        mcss_pkg::OP_CPL: begin
                            accNext = ~acc_reg;
                            zfNext = (acc_reg == 8'hff);
                        end
                        mcss_pkg::OP_SHL: begin
                            accNext = {acc_reg[6:0], 1'b0};
                            cfNext = acc_reg[7];
                            zfNext = (acc_reg[6:0] == 7'h00);
                        end
                        mcss_pkg::OP_ASHR: begin
                            accNext = {acc_reg[7], acc_reg[7:1]};
                            cfNext = acc_reg[0];
                            zfNext = (acc_reg[7:1] == 7'h00);
                        end
                        mcss_pkg::OP_ROLC: begin
                            accNext = {acc_reg[6:0], cf_reg};
                            cfNext = acc_reg[7];
                            zfNext = ({acc_reg[6:0], cf_reg} == 8'h00);
                        end
                        mcss_pkg::OP_RORC: begin
                            accNext = {cf_reg, acc_reg[7:1]};
                            cfNext = acc_reg[0];
                            zfNext = ({cf_reg, acc_reg[7:1]} == 8'h00);
                        end
                        default: begin
                            if (opHi == mcss_pkg::NIB_JMP || (isCond && condMet)) begin
                                pcNext = target;
                            end else if (opHi == mcss_pkg::NIB_ACCUMULATOR_JUMP_OP) begin
                                pcNext = accTarget;
                            end else if (opHi == mcss_pkg::NIB_INDEX) begin
                                tablePick = 1'b1;
                            end
                        end
                    endcase
                end else if (cyc_reg == mcss_pkg::ST_X1) begin
                    if (op_reg == mcss_pkg::OP_PUSH_A) begin
                        ramNext = ramWrite(dsp_reg, acc_reg);
                    end else if (opHi == mcss_pkg::NIB_INDEX) begin
                        accNext = pmData;
                        zfNext = (pmData == 8'h00);
                    end
                end else if (cyc_reg == mcss_pkg::ST_X2) begin
                    if (op_reg == mcss_pkg::OP_LDX_DIR) begin
                        xNext = ramRdata;
                    end else if (op_reg == mcss_pkg::OP_LDA_DIR ||
                                 op_reg == mcss_pkg::OP_LDA_IDX ||
                                 op_reg == mcss_pkg::OP_POP_A) begin
                        accNext = ramRdata;
                        zfNext = (ramRdata == 8'h00);
                    end
                    if (op_reg == mcss_pkg::OP_POP_A) begin
                        dspNext = dsp_reg + mcss_pkg::SP_STEP;
                    end
                end
            end
            default: begin
                stateNext = mcss_pkg::S_FETCH;
                cycNext = mcss_pkg::ST_FETCH;
            end
        endcase
        // the table read borrows the code port for one cycle
        pmAddrNext = tablePick ? accTarget : pcNext;
    end

    // pc has no read path to acc or data ram except via frames
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= mcss_pkg::S_FETCH;
            cyc_reg <= mcss_pkg::ST_FETCH;
            op_reg <= '0;
            opnd_reg <= '0;
            pc_reg <= mcss_pkg::PC_RESET;
            pmAddr_reg <= mcss_pkg::PC_RESET;
            acc_reg <= '0;
            x_reg <= '0;
            psp_reg <= mcss_pkg::SP_RESET;
            dsp_reg <= mcss_pkg::SP_RESET;
            {cf_reg, zf_reg, ie_reg, isIrq_reg, irqAck_reg} <= '0;
            hold_reg <= '0;
            ram_reg <= '0;
        end else begin
            state_reg <= stateNext;
            cyc_reg <= cycNext;
            op_reg <= opNext;
            opnd_reg <= opndNext;
            pc_reg <= pcNext;
            pmAddr_reg <= pmAddrNext;
            acc_reg <= accNext;
            x_reg <= xNext;
            psp_reg <= pspNext;
            dsp_reg <= dspNext;
            {cf_reg, zf_reg, ie_reg, isIrq_reg, irqAck_reg} <=
                {cfNext, zfNext, ieNext, irqNext, ackNext};
            hold_reg <= holdNext;
            ram_reg <= ramNext;
        end
    end

    assign pmAddr = pmAddr_reg;
    assign ramReq = ram_reg;
    assign irqAck = irqAck_reg;
    assign intEnabled = ie_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    wire inX0 = (state_reg == mcss_pkg::S_EXEC) && (cyc_reg == mcss_pkg::ST_X0);
    wire irqTake = (state_reg == mcss_pkg::S_FETCH) && irqReq && ie_reg;

    sequence SEQ_SAVE_FIRST;
        ramReq.we && (ramReq.addr == $past(psp_reg, 3));
    endsequence
    sequence SEQ_SAVE_SECOND;
        ramReq.we && (ramReq.addr == $past(psp_reg, 4) + mcss_pkg::SP_STEP);
    endsequence

    AST_RESET_FETCH: assert property ($past(rst) |-> pmAddr == mcss_pkg::PC_RESET)
        else $error("first fetch after reset not at address zero");
    AST_PAGE_HOLD: assert property (
        (state_reg == mcss_pkg::S_FETCH && !irqTake) |=> pc_reg[13:8] == $past(pc_reg[13:8]))
        else $error("fetch changed the upper program counter bits");
    AST_IRQ_SAVE: assert property (
        irqTake |=> !ie_reg ##2 SEQ_SAVE_FIRST ##1 SEQ_SAVE_SECOND)
        else $error("interrupt frame not saved upward at stack pointer");
    AST_IRQ_RETURN: assert property (
        (inX0 && isRet && op_reg == mcss_pkg::OP_INT_RET) |=>
        (psp_reg == $past(psp_reg) - mcss_pkg::SP_STEP) ##2
        (psp_reg == $past(psp_reg, 3) - mcss_pkg::FRAME_BYTES) ##2 ie_reg)
        else $error("interrupt return stack walk or enable wrong");
    AST_CALL_PUSH: assert property (
        (inX0 && isCall && !isIrq_reg) |-> ##2 psp_reg == $past(psp_reg, 2) + mcss_pkg::FRAME_BYTES)
        else $error("call did not advance stack pointer by two");
    AST_RET_FLAGS: assert property (
        (inX0 && isRet && op_reg == mcss_pkg::OP_SUB_RET) |-> ##5
        (cf_reg == $past(cf_reg, 5)) && (zf_reg == $past(zf_reg, 5)) &&
        (psp_reg == $past(psp_reg, 5) - mcss_pkg::FRAME_BYTES))
        else $error("subroutine return touched flags or stack pointer wrongly");
    AST_PSP_LOAD: assert property (
        (inX0 && !isIrq_reg && op_reg == mcss_pkg::OP_PSP_LOAD) |=> psp_reg == $past(acc_reg))
        else $error("stack pointer not loaded from accumulator");
    AST_PUSH_WRITE: assert property (
        (inX0 && op_reg == mcss_pkg::OP_PUSH_A) |=> ##1
        ramReq.we && (ramReq.addr == $past(dsp_reg, 2) - mcss_pkg::SP_STEP))
        else $error("push did not write at decremented data stack pointer");
    AST_COND_SKIP: assert property (
        (inX0 && isCond && !condMet) |=> ##1
        (state_reg == mcss_pkg::S_FETCH) && (pc_reg == $past(pc_reg, 2)))
        else $error("untaken branch not finished in four cycles");
    AST_LOAD_DIRECT: assert property (
        (inX0 && op_reg == mcss_pkg::OP_LDA_DIR) |-> ##3 state_reg == mcss_pkg::S_FETCH)
        else $error("direct accumulator load not five cycles");
endmodule

// >>> mcss_mem_model.sv
`timescale 1ns/1ps
module mcss_mem_model (
    input wire logic clk,
    input wire logic [13:0] pmAddr,
    output logic [7:0] pmData,
    input wire mcss_pkg::mcss_ram_req_s ramReq,
    output logic [7:0] ramRdata
);
    logic [7:0] rom [0:16383];
    logic [7:0] ram [0:255];

    // program memory answers in the same cycle, like a plain rom
    assign pmData = rom[pmAddr];

    initial ramRdata = 8'h00;

    // read data holds one cycle only; afterwards the bus flips so stale data never matches
    always @(posedge clk) begin
        if (ramReq.we) begin
            ram[ramReq.addr] <= ramReq.wdata;
        end
        ramRdata <= ramReq.re ? ram[ramReq.addr] : ~ramRdata;
    end
endmodule

// >>> mcss_core_tb.sv
`timescale 1ns/1ps
module mcss_core_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [13:0] pmAddr;
    logic [7:0] pmData;
    mcss_pkg::mcss_ram_req_s ramReq;
    logic [7:0] ramRdata;
    logic irqReq = 1'b0;
    logic [13:0] irqVector = 14'h0300;
    logic irqAck;
    logic intEnabled;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    logic hit;

    always #10 clk = ~clk;

    mcss_core i_dut (.clk(clk), .rst(rst), .pmAddr(pmAddr), .pmData(pmData), .ramReq(ramReq),
        .ramRdata(ramRdata), .irqReq(irqReq), .irqVector(irqVector), .irqAck(irqAck),
        .intEnabled(intEnabled));
    mcss_mem_model i_mem (.clk(clk), .pmAddr(pmAddr), .pmData(pmData), .ramReq(ramReq),
        .ramRdata(ramRdata));

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // a hang costs a mismatch and ends the run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // rom defaults to the reserved opcode, which runs as a one-byte no-op
    task automatic start();
        for (int i = 0; i < 16384; i++) i_mem.rom[i] = 8'h1e;
        @(negedge clk);
        rst = 1'b1;
    endtask

    task automatic release_rst();
        repeat (10) @(negedge clk);
        rst = 1'b0;
    endtask

    task automatic wait_pc(input logic [13:0] a, input int lim);
        hit = 1'b0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(negedge clk);
            hit = (pmAddr === a);
        end
    endtask

    task automatic t_reset();
        start();
        repeat (3) @(negedge clk);
        chk("reset pc", 16'h0000, {2'b00, pmAddr});
        chk("reset ie", 16'h0000, {15'h0000, intEnabled});
        release_rst();
        wait_pc(14'h0001, 4);
        chk("first fetch advance", 16'h0001, {15'h0000, hit});
        $display("test reset done");
    endtask

    task automatic t_call();
        start();
        i_mem.rom[0] = 8'h52;
        i_mem.rom[1] = 8'h34;
        i_mem.rom[14'h0234] = 8'h3f;
        release_rst();
        wait_pc(14'h0234, 20);
        chk("call target", 16'h0001, {15'h0000, hit});
        chk("frame low pc", 16'h0002, {8'h00, i_mem.ram[0]});
        chk("frame flags pc high", 16'h0000, {8'h00, i_mem.ram[1]});
        wait_pc(14'h0002, 20);
        chk("return address", 16'h0001, {15'h0000, hit});
        $display("test call done");
    endtask

    task automatic t_push();
        start();
        i_mem.ram[8'h40] = 8'h5a;
        i_mem.ram[8'hff] = 8'h00;
        i_mem.rom[0] = 8'h1a;
        i_mem.rom[1] = 8'h40;
        i_mem.rom[2] = 8'h2e;
        release_rst();
        wait_pc(14'h0004, 30);
        repeat (3) @(negedge clk);
        chk("push wrap to top", 16'h005a, {8'h00, i_mem.ram[8'hff]});
        $display("test push done");
    endtask

    // data stack moved to 20h first, psp loaded from an indexed read
    task automatic t_ops();
        start();
        i_mem.ram[8'h10] = 8'h20;
        i_mem.ram[8'h11] = 8'hc3;
        i_mem.ram[8'h12] = 8'h08;
        i_mem.rom[0] = 8'h1a;
        i_mem.rom[1] = 8'h10;
        i_mem.rom[2] = 8'h2d;
        i_mem.rom[3] = 8'h1a;
        i_mem.rom[4] = 8'h11;
        i_mem.rom[5] = 8'h2e;
        i_mem.rom[6] = 8'h1c;
        i_mem.rom[7] = 8'h05;
        i_mem.rom[8] = 8'h1b;
        i_mem.rom[9] = 8'h0d;
        i_mem.rom[10] = 8'h60;
        i_mem.rom[11] = 8'h52;
        i_mem.rom[12] = 8'h00;
        i_mem.rom[14'h0200] = 8'h2f;
        i_mem.rom[14'h0201] = 8'h3a;
        i_mem.rom[14'h0202] = 8'he0;
        i_mem.rom[14'h0203] = 8'h00;
        i_mem.rom[14'h003c] = 8'h3f;
        release_rst();
        wait_pc(14'h0200, 60);
        chk("call after operand ops", 16'h0001, {15'h0000, hit});
        chk("push below fifo area", 16'h00c3, {8'h00, i_mem.ram[8'h1f]});
        chk("frame at loaded psp", 16'h000d, {8'h00, i_mem.ram[8'h08]});
        chk("frame flags at psp", 16'h0000, {8'h00, i_mem.ram[8'h09]});
        wait_pc(14'h003c, 30);
        chk("pop complement acc jump", 16'h0001, {15'h0000, hit});
        wait_pc(14'h000d, 20);
        chk("return after psp load", 16'h0001, {15'h0000, hit});
        $display("test ops done");
    endtask

    task automatic t_flow();
        start();
        i_mem.rom[0] = 8'ha5;
        i_mem.rom[1] = 8'h10;
        i_mem.rom[2] = 8'hb0;
        i_mem.rom[3] = 8'hff;
        i_mem.rom[14'h00ff] = 8'h1f;
        release_rst();
        wait_pc(14'h00ff, 20);
        chk("jz not taken then jnz taken", 16'h0001, {15'h0000, hit});
        wait_pc(14'h0100, 10);
        chk("page advance", 16'h0001, {15'h0000, hit});
        $display("test flow done");
    endtask

    task automatic t_irq();
        start();
        i_mem.rom[0] = 8'h72;
        i_mem.rom[14'h0300] = 8'h73;
        release_rst();
        repeat (8) @(negedge clk);
        irqReq = 1'b1;
        @(negedge clk);
        chk("irq ack pulse", 16'h0001, {15'h0000, irqAck});
        @(negedge clk);
        chk("irq ack ends", 16'h0000, {15'h0000, irqAck});
        wait_pc(14'h0300, 30);
        irqReq = 1'b0;
        chk("vector reached", 16'h0001, {15'h0000, hit});
        chk("ie cleared", 16'h0000, {15'h0000, intEnabled});
        chk("irq frame low pc", 16'h0002, {8'h00, i_mem.ram[0]});
        chk("irq frame flags", 16'h0000, {8'h00, i_mem.ram[1]});
        wait_pc(14'h0002, 20);
        chk("resume address", 16'h0001, {15'h0000, hit});
        chk("ie restored", 16'h0001, {15'h0000, intEnabled});
        $display("test irq done");
    endtask

    initial begin
        t_reset();
        t_call();
        t_push();
        t_ops();
        t_flow();
        t_irq();
        test_done();
    end
endmodule
